// ---- src_pkg.sv ----
// Contract
// - Johnson upper stages copy the stage below
// - Johnson stage zero loads inverted top stage
// - Johnson counter has exactly twelve states
// - Johnson sequence 0,1,3,7,F,1F,3F,3E,3C,38,30,20
// - Basic feedback is XNOR of stages one, two
// - Feedback drives stage zero only, rest shift
// - Basic sequence 0,1,3,6,5,2,4, seven states
// - Basic all-ones state locks, never entered counting
// - Modified variant goes from 3 to 7
// - Modified sequence 0,1,3,7,6,5,2,4, eight states
// - Modified stage zero uses the three-term equation
// - Code weights stages one, two and four
`default_nettype none

package src_pkg;

    // ***************************************
    // Counter variants
    // ***************************************
    typedef enum {
        SRC_JOHNSON,
        SRC_BASIC,
        SRC_MODIFIED
    } src_variant_e;

    // ***************************************
    // Widths and periods
    // ***************************************
    localparam int STATE_W = 6;          // Widest variant
    localparam int JOHNSON_STAGES = 6;   // Twisted ring length
    localparam int FEEDBACK_STAGES = 3;  // Three-stage feedback length
    localparam int JOHNSON_STATES = 12;  // Twice the stages
    localparam int BASIC_STATES = 7;     // All but the lock-up code
    localparam int MODIFIED_STATES = 8;  // Every code
    localparam int AGE_W = 4;            // Wide enough for twelve

    // ***************************************
    // Codes and masks
    // ***************************************
    localparam logic [5:0] RESET_STATE = 6'h00;
    localparam logic [5:0] JOHNSON_MASK = 6'h3F;
    localparam logic [5:0] FEEDBACK_MASK = 6'h07;
    localparam logic [5:0] JOHNSON_FULL = 6'h3F;
    localparam logic [5:0] JOHNSON_DROP = 6'h3E;
    localparam logic [5:0] JOHNSON_LAST = 6'h20;
    localparam logic [5:0] LOCKUP_STATE = 6'h07;
    localparam logic [5:0] CODE_THREE = 6'h03;
    localparam logic [5:0] CODE_SIX = 6'h06;
    localparam logic [5:0] CODE_FIVE = 6'h05;
    localparam logic [5:0] CODE_TWO = 6'h02;

endpackage : src_pkg

`default_nettype wire

// ---- src_shift_chain.sv ----
`timescale 1ns/1ps
`default_nettype none

module src_shift_chain #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic syncClear,
    input wire logic loadEn,
    input wire logic [WIDTH-1:0] loadValue,
    // Feedback into the least significant stage
    input wire logic feedbackIn,
    // Stage outputs
    output logic [WIDTH-1:0] stageQ
);

    // ***************************************
    // Shift chain
    // ***************************************
    // Clear beats load, load beats counting
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stageQ <= '0;
        end else if (syncClear) begin
            stageQ <= '0;
        end else if (loadEn) begin
            stageQ <= loadValue;
        end else begin
            // Only stage zero sees feedback; the rest copy below
            stageQ <= {stageQ[WIDTH-2:0], feedbackIn};
        end
    end

endmodule : src_shift_chain

`default_nettype wire

// ---- src_counter_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module src_counter_top #(
    // Build-time choice of counter
    parameter src_pkg::src_variant_e VARIANT = src_pkg::SRC_JOHNSON
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Same-domain control
    input wire logic syncClear,
    input wire logic loadEn,
    input wire logic [5:0] loadValue,
    // Counter state, stage zero in bit 0
    output logic [5:0] countState,
    // Status
    output logic wrapPulse_ff,
    output logic lockedUp_ff
);

    // ***************************************
    // Variant shape
    // ***************************************
    // Stage count follows the chosen variant
    localparam int STAGES = (VARIANT == src_pkg::SRC_JOHNSON) ?
        src_pkg::JOHNSON_STAGES : src_pkg::FEEDBACK_STAGES;
    // Mask that drops bits beyond the chain
    localparam logic [5:0] STAGE_MASK = (VARIANT == src_pkg::SRC_JOHNSON) ?
        src_pkg::JOHNSON_MASK : src_pkg::FEEDBACK_MASK;
    // States in one full period
    localparam int PERIOD = (VARIANT == src_pkg::SRC_JOHNSON) ?
        src_pkg::JOHNSON_STATES : ((VARIANT == src_pkg::SRC_BASIC) ?
        src_pkg::BASIC_STATES : src_pkg::MODIFIED_STATES);
    localparam logic [3:0] PERIOD_CNT = 4'(PERIOD);

    // ***************************************
    // Feedback functions
    // ***************************************
    // Twisted ring: invert the top stage
    function automatic logic fbJohnson(input logic [5:0] s);
        return ~s[5];
    endfunction : fbJohnson

    // Basic: high when stages one and two agree
    function automatic logic fbBasic(input logic [5:0] s);
        return ~(s[1] ^ s[2]);
    endfunction : fbBasic

    // Modified: shifts a one after code three to reach seven
    function automatic logic fbModified(input logic [5:0] s);
        return (~s[1] & ~s[2]) | (s[0] & ~s[2]) | (~s[0] & s[1] & s[2]);
    endfunction : fbModified

    // Feedback of the variant in use
    function automatic logic fbSelect(input logic [5:0] s);
        logic fb;
        fb = 1'b0;
        case (VARIANT)
            src_pkg::SRC_JOHNSON: fb = fbJohnson(s);
            src_pkg::SRC_BASIC: fb = fbBasic(s);
            src_pkg::SRC_MODIFIED: fb = fbModified(s);
            default: fb = 1'b0;
        endcase
        return fb;
    endfunction : fbSelect

    // Next code when counting; bit weights 1, 2, 4 and up
    function automatic logic [5:0] nextCode(input logic [5:0] s);
        return {s[4:0], fbSelect(s)} & STAGE_MASK;
    endfunction : nextCode

    // ***************************************
    // Counter core
    // ***************************************
    logic [STAGES-1:0] stageQ;   // Chain flip-flops
    logic feedbackBit;           // Into stage zero
    logic countStep;             // Plain counting this cycle
    logic [5:0] nxtState;        // What the chain will hold next

    // Feedback from the current state only
    assign feedbackBit = fbSelect(countState);

    // Counting whenever neither clear nor load is asked
    assign countStep = ~syncClear & ~loadEn;

    // One chain, one clock for all stages
    src_shift_chain #(
        .WIDTH(STAGES)
    ) u_chain (
        .clk_sys(clk_sys),
        .rst(rst),
        .syncClear(syncClear),
        .loadEn(loadEn),
        .loadValue(loadValue[STAGES-1:0]),
        .feedbackIn(feedbackBit),
        .stageQ(stageQ)
    );

    // Widen the short chains with zeros above
    generate
        if (STAGES < src_pkg::STATE_W) begin : g_pad
            assign countState = {{(src_pkg::STATE_W - STAGES){1'b0}}, stageQ};
        end else begin : g_full
            assign countState = stageQ;
        end
    endgenerate

    // Mirror of the chain priority, for the status flags
    always_comb begin
        if (syncClear) begin
            nxtState = src_pkg::RESET_STATE;
        end else if (loadEn) begin
            nxtState = loadValue & STAGE_MASK;
        end else begin
            nxtState = nextCode(countState);
        end
    end

    // ***************************************
    // Status flags
    // ***************************************
    // Wrap marks a return to zero by counting, not by clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrapPulse_ff <= 1'b0;
        end else begin
            wrapPulse_ff <= countStep && (nxtState == src_pkg::RESET_STATE);
        end
    end

    // Lock-up only exists in the basic variant
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lockedUp_ff <= 1'b0;
        end else begin
            // Once loaded, all ones feeds itself forever
            lockedUp_ff <= (VARIANT == src_pkg::SRC_BASIC) &&
                (nxtState == src_pkg::LOCKUP_STATE);
        end
    end

    // ***************************************
    // Checking helpers
    // ***************************************
    // Steps since zero was last seen; only valid after a clear
    logic [3:0] ageCnt;
    logic runValid;

    // A load breaks the run, since any code may be loaded
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ageCnt <= 4'h0;
            runValid <= 1'b0;
        end else if (syncClear) begin
            ageCnt <= 4'h0;
            runValid <= 1'b1;
        end else if (loadEn) begin
            ageCnt <= 4'h0;
            runValid <= 1'b0;
        end else if (countState == src_pkg::RESET_STATE) begin
            ageCnt <= 4'h1;
        end else if (ageCnt != 4'hF) begin
            ageCnt <= ageCnt + 4'h1;
        end
    end

    // ***************************************
    // Assertions
    // ***************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Upper stages are a plain shift of the lower ones
    a_chain_shift: assert property (
        countStep |=> stageQ[STAGES-1:1] == $past(stageQ[STAGES-2:0])
    ) else $error("upper stage did not copy the stage below");

    // Ring feedback inverts the top stage
    a_ring_invert: assert property (
        (VARIANT == src_pkg::SRC_JOHNSON) && countStep
        |=> countState[0] == !$past(countState[5])
    ) else $error("ring feedback is not the inverted top stage");

    // Return to zero after exactly one full period
    a_period_len: assert property (
        runValid && (countState == src_pkg::RESET_STATE) && (ageCnt != 4'h0)
        |-> ageCnt == PERIOD_CNT
    ) else $error("period length is wrong");

    // No run lasts longer than the period
    a_period_bound: assert property (
        runValid |-> ageCnt <= PERIOD_CNT
    ) else $error("counter overran its period");

    // Ring turns over from full to dropping
    a_ring_turn: assert property (
        (VARIANT == src_pkg::SRC_JOHNSON) && countStep &&
        (countState == src_pkg::JOHNSON_FULL)
        |=> countState == src_pkg::JOHNSON_DROP
    ) else $error("ring did not go from 3F to 3E");

    // Ring ends its period on 20 then zero
    a_ring_last: assert property (
        (VARIANT == src_pkg::SRC_JOHNSON) && countStep &&
        (countState == src_pkg::JOHNSON_LAST)
        |=> countState == src_pkg::RESET_STATE
    ) else $error("ring did not go from 20 to 0");

    // Basic feedback is high when stages one and two agree
    a_basic_xnor: assert property (
        (VARIANT == src_pkg::SRC_BASIC) && countStep
        |=> countState[0] == ($past(countState[1]) == $past(countState[2]))
    ) else $error("basic feedback is not the equality of stages one and two");

    // Basic middle of the sequence
    a_basic_walk: assert property (
        (VARIANT == src_pkg::SRC_BASIC) && (countState == src_pkg::CODE_THREE)
        && countStep ##1 countStep [*2]
        |=> countState == src_pkg::CODE_TWO && $past(countState, 2) == src_pkg::CODE_SIX
    ) else $error("basic sequence 3, 6, 5, 2 broken");

    // All ones holds itself in the basic variant
    a_basic_lockup: assert property (
        (VARIANT == src_pkg::SRC_BASIC) && countStep &&
        (countState == src_pkg::LOCKUP_STATE)
        |=> countState == src_pkg::LOCKUP_STATE && lockedUp_ff
    ) else $error("basic lock-up state did not hold");

    // Counting from zero never reaches all ones
    a_basic_no_lock: assert property (
        (VARIANT == src_pkg::SRC_BASIC) && runValid
        |-> countState != src_pkg::LOCKUP_STATE && !lockedUp_ff
    ) else $error("basic counter entered the lock-up state");

    // Modified variant passes through seven
    a_mod_seven: assert property (
        (VARIANT == src_pkg::SRC_MODIFIED) && (countState == src_pkg::CODE_THREE)
        && countStep ##1 countStep
        |=> countState == src_pkg::CODE_SIX &&
            $past(countState) == src_pkg::LOCKUP_STATE
    ) else $error("modified sequence 3, 7, 6 broken");

    // Modified stage zero from the sum of products
    a_mod_feedback: assert property (
        (VARIANT == src_pkg::SRC_MODIFIED) && countStep
        |=> countState[0] == ((!$past(countState[1]) && !$past(countState[2]))
            || ($past(countState[0]) && !$past(countState[2]))
            || (!$past(countState[0]) && $past(countState[1]) && $past(countState[2])))
    ) else $error("modified stage zero is not the three-term sum");

    // Modified variant steps from six to five
    a_mod_six_five: assert property (
        (VARIANT == src_pkg::SRC_MODIFIED) && countStep &&
        (countState == src_pkg::CODE_SIX)
        |=> countState == src_pkg::CODE_FIVE
    ) else $error("modified step from 6 did not reach 5");

    // Clear gives zero and no wrap flag
    a_clear_zero: assert property (
        syncClear |=> countState == src_pkg::RESET_STATE && !wrapPulse_ff
    ) else $error("clear did not zero the stages");

    // Wrap only with a zero state reached by counting
    a_wrap_zero: assert property (
        wrapPulse_ff |-> countState == src_pkg::RESET_STATE &&
            $past(countStep)
    ) else $error("wrap pulse without a counted return to zero");

    // Lock flag follows the all-ones code, loaded or not
    a_lock_flag: assert property (
        (VARIANT == src_pkg::SRC_BASIC)
        |-> lockedUp_ff == (countState == src_pkg::LOCKUP_STATE)
    ) else $error("lock flag does not match the all-ones state");

    // ***************************************
    // Cover points
    // ***************************************
    // A complete period after a clear
    c_full_period: cover property (
        runValid && (countState == src_pkg::RESET_STATE) && (ageCnt == PERIOD_CNT)
    );

    // Loaded into lock-up
    c_lockup: cover property (
        lockedUp_ff ##1 lockedUp_ff
    );

    // The extra state of the modified variant
    c_mod_seven: cover property (
        (VARIANT == src_pkg::SRC_MODIFIED) && (countState == src_pkg::LOCKUP_STATE)
    );

    // Clear during counting
    c_clear_mid: cover property (
        (countState != src_pkg::RESET_STATE) && syncClear
    );

    // Basic variant walks from six to five
    c_basic_walk: cover property (
        (VARIANT == src_pkg::SRC_BASIC) && (countState == src_pkg::CODE_SIX)
        ##1 (countState == src_pkg::CODE_FIVE)
    );

endmodule : src_counter_top

`default_nettype wire

// ---- shift_register_counters_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module shift_register_counters_tb;

    // ***************************************
    // Clock, reset and shared stimulus
    // ***************************************
    logic clk_sys = 1'b0; // 20 MHz system clock
    logic rst = 1'b1; // Asynchronous reset, high at start
    logic syncClear = 1'b0; // Synchronous clear
    logic loadEn = 1'b0; // Preload strobe
    logic [5:0] loadValue = 6'h00; // Preload code
    // Outputs of the three variants
    logic [5:0] cntJ, cntB, cntM;
    logic wrapJ, wrapB, wrapM, lockJ, lockB, lockM;
    // Expected states, pending note and the note queue
    logic [5:0] eJ, eB, eM;
    logic [23:0] pend, expV, actV;
    logic [23:0] expQ[$];
    int errorCnt = 0;
    int checkCount = 0;

    // ***************************************
    // Devices under test, one per variant
    // ***************************************
    src_counter_top #(.VARIANT(src_pkg::SRC_JOHNSON)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .syncClear(syncClear), .loadEn(loadEn), .loadValue(loadValue), .countState(cntJ),
        .wrapPulse_ff(wrapJ), .lockedUp_ff(lockJ));
    src_counter_top #(.VARIANT(src_pkg::SRC_BASIC)) u_dutBasic (.clk_sys(clk_sys), .rst(rst),
        .syncClear(syncClear), .loadEn(loadEn), .loadValue(loadValue), .countState(cntB),
        .wrapPulse_ff(wrapB), .lockedUp_ff(lockB));
    src_counter_top #(.VARIANT(src_pkg::SRC_MODIFIED)) u_dutMod (.clk_sys(clk_sys), .rst(rst),
        .syncClear(syncClear), .loadEn(loadEn), .loadValue(loadValue), .countState(cntM),
        .wrapPulse_ff(wrapM), .lockedUp_ff(lockM));

    // Free-running clock, 50 ns period
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    // ***************************************
    // Reference model
    // ***************************************
    // Next state of every variant from the stage equations
    task automatic advance(input logic clr, input logic ld, input logic [5:0] v);
        logic [5:0] nJ, nB, nM;
        logic wJ, wB, wM;
        nJ = {eJ[4:0], ~eJ[5]};
        nB = {3'h0, eB[1:0], ~(eB[1] ^ eB[2])};
        nM = {3'h0, eM[1:0], (~eM[1] & ~eM[2]) | (eM[0] & ~eM[2]) |
            (~eM[0] & eM[1] & eM[2])};
        if (clr) begin
            // Clear outranks the preload
            nJ = 6'h00;
            nB = 6'h00;
            nM = 6'h00;
        end else if (ld) begin
            // Three-stage variants keep only their low bits
            nJ = v;
            nB = {3'h0, v[2:0]};
            nM = {3'h0, v[2:0]};
        end
        // Wrap flags only for a counted return to zero
        wJ = !clr && !ld && (nJ == 6'h00);
        wB = !clr && !ld && (nB == 6'h00);
        wM = !clr && !ld && (nM == 6'h00);
        pend = {nJ, wJ, 1'b0, nB, wB, nB == 6'h07, nM, wM, 1'b0};
        eJ = nJ;
        eB = nB;
        eM = nM;
    endtask : advance

    // ***************************************
    // Driver tasks
    // ***************************************
    // One clock: note what is now visible, then drive new inputs
    task automatic step(input logic clr, input logic ld, input logic [5:0] v);
        @(posedge clk_sys);
        #1;
        expQ.push_back(pend);
        syncClear = clr;
        loadEn = ld;
        loadValue = v;
        advance(clr, ld, v);
    endtask : step

    // Reset pulse; zero state is checked while it is held
    task automatic resetDut(input int n);
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        syncClear = 1'b0;
        loadEn = 1'b0;
        eJ = 6'h00;
        eB = 6'h00;
        eM = 6'h00;
        pend = 24'h000000;
        expQ.push_back(pend);
        repeat (n) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        // Counting starts at the first edge after release
        advance(1'b0, 1'b0, loadValue);
    endtask : resetDut

    // Verdict and end of run
    task automatic conclude();
        if (errorCnt == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // ***************************************
    // Monitor: oldest note against the outputs
    // ***************************************
    // Samples 2 ns after the edge so the edge's updates have landed
    initial begin
        forever begin
            @(posedge clk_sys);
            #2;
            if (expQ.size() > 0) begin
                expV = expQ.pop_front();
                actV = {cntJ, wrapJ, lockJ, cntB, wrapB, lockB, cntM, wrapM, lockM};
                checkCount++;
                if (actV !== expV) begin
                    errorCnt++;
                    $display("unexpected at %0t: got %h expected %h", $time, actV, expV);
                end
            end
        end
    end

    // ***************************************
    // Main sequence
    // ***************************************
    initial begin
        logic [5:0] rv;
        void'($urandom(2));
        resetDut(20);
        // Two full Johnson periods, several feedback periods
        repeat (26) step(1'b0, 1'b0, 6'h00);
        // All-ones preload: basic locks, modified leaves it
        step(1'b0, 1'b1, 6'h07);
        repeat (5) step(1'b0, 1'b0, 6'h00);
        // Clear and preload together, then preload back to back
        step(1'b1, 1'b1, 6'h15);
        step(1'b0, 1'b1, 6'h20);
        step(1'b0, 1'b1, 6'h3F);
        step(1'b0, 1'b1, 6'h03);
        repeat (3) step(1'b0, 1'b0, 6'h00);
        // Random clears and preloads across all codes
        repeat (300) begin
            rv = 6'($urandom);
            step(($urandom % 16) == 0, ($urandom % 4) == 0, rv);
        end
        // Reset in mid-sequence, then count again
        repeat (4) step(1'b0, 1'b0, 6'h00);
        resetDut(3);
        repeat (14) step(1'b0, 1'b0, 6'h00);
        repeat (2) @(posedge clk_sys);
        #3;
        conclude();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        errorCnt++;
        conclude();
    end

endmodule : shift_register_counters_tb

`default_nettype wire
